// >>> program_status_register.v
/*
 Combined processor status word: condition flags with sticky saturation,
 active exception number, and execution state (block phase or multi
 transfer resume index). Datapath and exception logic drive the update
 strobes; software reaches it through status-move read and write strobes.
 Assumes all inputs come from logic on clk, strobes are one-cycle pulses.
*/
`include "program_status_register_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module program_status_register (
    input wire clk,
    input wire rst,
    // Flag-setting instruction result
    input wire flag_update,
    input wire flag_n_in,
    input wire flag_z_in,
    input wire flag_c_in,
    input wire flag_v_in,
    input wire sat_event,
    // Status move instructions
    input wire sw_write,
    input wire [2:0] sw_write_sel,
    input wire [31:0] sw_wdata,
    input wire sw_read,
    input wire [2:0] sw_read_sel,
    output reg [31:0] sw_rdata,
    output reg sw_rvalid,
    // Exception entry and return
    input wire exc_entry,
    input wire exc_entry_ext,
    input wire [8:0] exc_entry_num,
    output reg entry_refused,
    output reg [31:0] stacked_word,
    input wire exc_return,
    input wire [8:0] exc_return_num,
    input wire [31:0] exc_return_word,
    output reg resume_valid,
    output reg [3:0] resume_index,
    // Conditional block
    input wire cond_block_start,
    input wire [7:0] cond_block_code,
    input wire cond_instr_done,
    output reg cond_active,
    output reg [3:0] cond_code,
    // Multi transfer
    input wire multi_suspend,
    input wire [3:0] multi_next_reg,
    input wire multi_done,
    // True status word for the pipeline
    output reg [31:0] status_word,
    output reg isa_mode
);

    // ==========================================================
    // State
    reg flag_n;
    reg flag_z;
    reg flag_c;
    reg flag_v;
    reg flag_q;
    reg [8:0] exc_id;
    reg [7:0] phase;
    reg [3:0] resume_idx;
    reg holding_resume;
    reg [8:0] next_exc;
    reg next_refuse;
    reg [31:0] true_word;
    reg [31:0] read_word;
    reg [7:0] next_phase;
    wire [8:0] ext_num;

    // External line number shifted past the system range
    assign ext_num = exc_entry_num + `EXC_IRQ_BASE;

    // ==========================================================
    // Exception number decode
    // Reserved system numbers are refused on entry; reset (0) and exception return can still load them
    always @*
    begin
        next_refuse = 1'b0;
        next_exc = exc_entry_num;
        if (exc_entry_ext)
        begin
            next_exc = ext_num;
        end
        else
        begin
            case (exc_entry_num)
                `EXC_NMI, `EXC_HARD, `EXC_MEM, `EXC_BUS, `EXC_USAGE: next_refuse = 1'b0;
                `EXC_SVC, `EXC_PEND_SVC, `EXC_TICK: next_refuse = 1'b0;
                `EXC_THREAD, `EXC_RSV1, `EXC_DBG_RSV, `EXC_RSV13: next_refuse = 1'b1;
                default:
                begin
                    // 7..10 reserved; above 15 only via the external path
                    next_refuse = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // True combined word, three disjoint fields
    always @*
    begin
        true_word = `RST_WORD;
        true_word[`STAT_N_BIT] = flag_n;
        true_word[`STAT_Z_BIT] = flag_z;
        true_word[`STAT_C_BIT] = flag_c;
        true_word[`STAT_V_BIT] = flag_v;
        true_word[`STAT_Q_BIT] = flag_q;
        true_word[`STAT_ISA_BIT] = 1'b1;
        true_word[`STAT_EXC_MSB:0] = exc_id;
        if (holding_resume)
        begin
            // Phase bits 26:25 and 11:10 left at zero
            true_word[`IDX_HI:`IDX_LO] = resume_idx;
        end
        else
        begin
            true_word[`PH_A_HI:`PH_A_LO] = phase[1:0];
            true_word[`PH_B_HI:`PH_B_LO] = phase[7:2];
        end
    end

    // ==========================================================
    // Direct software read view
    // Execution-state part always reads zero, even the mode bit
    always @*
    begin
        read_word = `RST_WORD;
        if (sw_read_sel[`SEL_APP])
        begin
            read_word[`STAT_N_BIT:`APP_LO] = true_word[`STAT_N_BIT:`APP_LO];
        end
        if (sw_read_sel[`SEL_EXC])
        begin
            read_word[`STAT_EXC_MSB:0] = exc_id;
        end
        // Exec part select contributes nothing on purpose
    end

    // ==========================================================
    // Block phase advance: shift the mask, end after the last one
    always @*
    begin
        next_phase = phase;
        if (phase[2:0] == 3'h0)
        begin
            next_phase = `RST_PHASE;
        end
        else
        begin
            next_phase[4:0] = {phase[3:0], 1'b0};
        end
    end

    // ==========================================================
    // Condition flags
    always @(posedge clk)
    begin
        if (rst)
        begin
            {flag_n, flag_z, flag_c, flag_v} <= 4'h0;
        end
        else if (exc_return)
        begin
            flag_n <= exc_return_word[`STAT_N_BIT];
            flag_z <= exc_return_word[`STAT_Z_BIT];
            flag_c <= exc_return_word[`STAT_C_BIT];
            flag_v <= exc_return_word[`STAT_V_BIT];
        end
        else if (flag_update)
        begin
            // Only flag-setting instructions strobe this
            flag_n <= flag_n_in;
            flag_z <= flag_z_in;
            flag_c <= flag_c_in;
            flag_v <= flag_v_in;
        end
        else if (sw_write && sw_write_sel[`SEL_APP])
        begin
            flag_n <= sw_wdata[`STAT_N_BIT];
            flag_z <= sw_wdata[`STAT_Z_BIT];
            flag_c <= sw_wdata[`STAT_C_BIT];
            flag_v <= sw_wdata[`STAT_V_BIT];
        end
    end

    // ==========================================================
    // Sticky saturation: a saturation in the clear cycle wins
    always @(posedge clk)
    begin
        if (rst)
        begin
            flag_q <= 1'b0;
        end
        else if (sat_event)
        begin
            flag_q <= 1'b1;
        end
        else if (exc_return)
        begin
            flag_q <= exc_return_word[`STAT_Q_BIT];
        end
        else if (sw_write && sw_write_sel[`SEL_APP])
        begin
            // Non-saturating arithmetic never reaches here
            flag_q <= sw_wdata[`STAT_Q_BIT];
        end
    end

    // ==========================================================
    // Active exception number; software writes never touch it
    always @(posedge clk)
    begin
        if (rst)
        begin
            exc_id <= `RST_EXC;
            entry_refused <= 1'b0;
        end
        else
        begin
            entry_refused <= exc_entry & next_refuse;
            if (exc_entry && !next_refuse)
            begin
                exc_id <= next_exc;
            end
            else if (exc_return)
            begin
                exc_id <= exc_return_num;
            end
        end
    end

    // ==========================================================
    // Execution state: block phase or resume index, never both
    always @(posedge clk)
    begin
        if (rst)
        begin
            phase <= `RST_PHASE;
            resume_idx <= 4'h0;
            holding_resume <= 1'b0;
        end
        else if (exc_entry && !next_refuse)
        begin
            // Handler starts clean; true state went to the stack
            phase <= `RST_PHASE;
            resume_idx <= 4'h0;
            holding_resume <= 1'b0;
        end
        else if (exc_return)
        begin
            // Restore from stacked word; resume index if phase bits clear
            if (exc_return_word[`PH_A_HI:`PH_A_LO] == 2'h0 && exc_return_word[`PH_M_HI:`PH_M_LO] == 2'h0 &&
                exc_return_word[`IDX_HI:`IDX_LO] != 4'h0)
            begin
                resume_idx <= exc_return_word[`IDX_HI:`IDX_LO];
                holding_resume <= 1'b1;
                phase <= `RST_PHASE;
            end
            else
            begin
                phase <= {exc_return_word[`PH_B_HI:`PH_B_LO], exc_return_word[`PH_A_HI:`PH_A_LO]};
                resume_idx <= 4'h0;
                holding_resume <= 1'b0;
            end
        end
        else if (multi_suspend)
        begin
            resume_idx <= multi_next_reg;
            holding_resume <= (multi_next_reg != 4'h0); // Index zero: nothing to resume
            phase <= `RST_PHASE;
        end
        else if (multi_done)
        begin
            resume_idx <= 4'h0;
            holding_resume <= 1'b0;
        end
        else if (cond_block_start)
        begin
            phase <= cond_block_code;
            resume_idx <= 4'h0;
            holding_resume <= 1'b0;
        end
        else if (cond_instr_done && phase[3:0] != 4'h0)
        begin
            phase <= next_phase;
        end
        // Software writes to this part are dropped
    end

    // ==========================================================
    // Registered outputs
    always @(posedge clk)
    begin
        if (rst)
        begin
            sw_rdata <= `RST_WORD;
            sw_rvalid <= 1'b0;
            stacked_word <= `RST_WORD;
            resume_valid <= 1'b0;
            resume_index <= 4'h0;
            cond_active <= 1'b0;
            cond_code <= 4'h0;
            status_word <= `RST_WORD;
            isa_mode <= 1'b0;
        end
        else
        begin
            sw_rvalid <= sw_read;
            if (sw_read)
            begin
                sw_rdata <= read_word;
            end
            if (exc_entry && !next_refuse)
            begin
                stacked_word <= true_word;
            end
            // Level telling the load/store unit where to pick up, high while a resume index is held and no entry, return or multi_done strobe is seen
            resume_valid <= holding_resume & ~exc_entry & ~exc_return & ~multi_done;
            resume_index <= resume_idx;
            // Low mask bits set means a block is live
            cond_active <= ~holding_resume & (phase[3:0] != 4'h0);
            // Bit 4 picks base condition or its inverse
            cond_code <= phase[7:4];
            status_word <= true_word;
            isa_mode <= 1'b1;
        end
    end

endmodule // program_status_register

`default_nettype wire

// >>> program_status_register_defines.vh
/*
 Constants for the combined processor status word: field positions,
 exception numbers, reset values and write-select bits.
 Assumes it is included by bare name from the status word module.
*/
// Behaviour
// - Bit 31 follows negative or less-than result of last flag-setting op.
// - Bit 30 follows whether last flag-setting result was zero.
// - Bit 29 is carry on add, not-borrow on subtract.
// - Bit 28 follows signed overflow of last flag-setting op.
// - Bit 27 sets on any saturation and stays set until reset or clear.
// - Only a software write or an exception return clears the saturation flag; no auto clear.
// - Active exception number sits in bits 8:0; bits 31:9 read zero.
// - Numbers: 0 thread, 2..6 faults; 1 and 7..10 reserved.
// - 11 supervisor call, 14 pended service, 15 tick; 12, 13 reserved.
// - External interrupt line N is reported as exception number N+16.
// - Instruction-set mode bit is always 1 while executing.
// - Direct reads of execution-state bits give zero; writes are dropped.
// - Stacked word at exception entry carries true execution state.
// - Interrupted multi transfer saves next register index in bits 15:12.
// - Return resumes multi transfer at saved index, not first register.
// - While resume index is held, bits 26:25 and 11:10 stay zero.
// - Conditional block of up to four instructions after 16-bit opener.
// - Each block instruction uses base condition or its inverse.
// - Three parts are disjoint fields of one 32-bit word, any combination.
// - Writes to the exception number bits are ignored.
`ifndef PROGRAM_STATUS_REGISTER_DEFINES_VH
`define PROGRAM_STATUS_REGISTER_DEFINES_VH

// ==========================================================
// Field positions
`define STAT_N_BIT 31
`define STAT_Z_BIT 30
`define STAT_C_BIT 29
`define STAT_V_BIT 28
`define STAT_Q_BIT 27
`define STAT_ISA_BIT 24
`define STAT_EXC_MSB 8
`define STAT_EXC_W 9
`define APP_LO 27
`define PH_A_HI 26
`define PH_A_LO 25
`define IDX_HI 15
`define IDX_LO 12
`define PH_B_HI 15
`define PH_B_LO 10
`define PH_M_HI 11
`define PH_M_LO 10

// ==========================================================
// Part select bits for reads and writes
`define SEL_APP 0
`define SEL_EXC 1
`define SEL_EXEC 2

// ==========================================================
// Exception numbers
`define EXC_THREAD 9'h000
`define EXC_RSV1 9'h001
`define EXC_NMI 9'h002
`define EXC_HARD 9'h003
`define EXC_MEM 9'h004
`define EXC_BUS 9'h005
`define EXC_USAGE 9'h006
`define EXC_RSV_LO 9'h007
`define EXC_RSV_HI 9'h00a
`define EXC_SVC 9'h00b
`define EXC_DBG_RSV 9'h00c
`define EXC_RSV13 9'h00d
`define EXC_PEND_SVC 9'h00e
`define EXC_TICK 9'h00f
`define EXC_IRQ_BASE 9'h010

// ==========================================================
// Reset values
`define RST_FLAGS 5'h00
`define RST_EXC 9'h000
`define RST_PHASE 8'h00
`define RST_WORD 32'h00000000

`endif

// >>> psr_chk.sv
/*
 Checker for the status word: ties flags, exception number and
 execution state outputs to the strobes that cause them.
 Assumes it is bound to the status word module on its single clock.
*/
`timescale 1ns/10ps
`default_nettype none

module status_word_chk (
    input wire clk,
    input wire rst,
    input wire flag_update,
    input wire flag_n_in,
    input wire flag_z_in,
    input wire flag_c_in,
    input wire flag_v_in,
    input wire sat_event,
    input wire sw_write,
    input wire sw_read,
    input wire sw_rvalid,
    input wire [31:0] sw_rdata,
    input wire exc_entry,
    input wire exc_entry_ext,
    input wire [8:0] exc_entry_num,
    input wire entry_refused,
    input wire [31:0] stacked_word,
    input wire exc_return,
    input wire resume_valid,
    input wire [3:0] resume_index,
    input wire cond_active,
    input wire [31:0] status_word,
    input wire isa_mode
);
    // System numbers that an entry may not carry
    wire rsv = !(exc_entry_num inside {[9'h002:9'h006], 9'h00b, 9'h00e, 9'h00f});

    // ==========
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_flags_follow: assert property (flag_update && !exc_return |-> ##2
        status_word[31:28] == $past({flag_n_in, flag_z_in, flag_c_in, flag_v_in}, 2))
        else $error("flags not loaded");
    a_sat_sets: assert property (sat_event && !exc_return |-> ##2 status_word[27])
        else $error("saturation flag not set");
    a_sat_sticky: assert property ($fell(status_word[27]) |->
        $past(sw_write, 2) || $past(exc_return, 2))
        else $error("saturation flag cleared by itself");
    a_exec_reads_zero: assert property (sw_rvalid |-> sw_rdata[26:9] == 18'h00000)
        else $error("read shows execution state");
    a_read_answers: assert property (sw_read |=> sw_rvalid)
        else $error("read not answered");
    a_isa_running: assert property (!$past(rst) && !$past(rst, 2) |-> isa_mode && status_word[24])
        else $error("mode bit low while running");
    a_ext_number: assert property (exc_entry && exc_entry_ext ##1 !exc_entry && !exc_return |=>
        status_word[8:0] == $past(exc_entry_num, 2) + 9'h010)
        else $error("external number wrong");
    a_refuse_reserved: assert property (exc_entry && !exc_entry_ext |=> entry_refused == $past(rsv))
        else $error("entry refusal wrong");
    a_stack_mode: assert property (exc_entry && (exc_entry_ext || !rsv) |=> stacked_word[24])
        else $error("stacked word lacks mode bit");
    a_resume_bits_clear: assert property (resume_valid |-> !cond_active &&
        status_word[26:25] == 2'h0 && status_word[11:10] == 2'h0)
        else $error("block bits live beside resume index");
    a_resume_shown: assert property (resume_valid |->
        status_word[15:12] == resume_index && resume_index != 4'h0)
        else $error("resume index not shown");
endmodule // status_word_chk

`default_nettype wire

// >>> core_pipe_model.sv
/*
 Model of the pipeline's multi transfer: steps one register a cycle,
 suspends on request and restarts from the held resume index.
 Assumes bench control changes on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none

module core_pipe_model (
    input wire logic clk,
    input wire logic start,
    input wire logic irq,
    input wire logic resume_valid,
    input wire logic [3:0] resume_index,
    output var logic multi_suspend,
    output var logic [3:0] multi_next_reg,
    output var logic multi_done,
    output var logic [3:0] first_reg
);
    logic busy = 1'b0;
    logic [3:0] cur = 4'h0;

    // Outputs start quiet
    initial {multi_suspend, multi_done, multi_next_reg, first_reg} = 10'h000;

    // Index is only meaningful with the suspend pulse, so it toggles otherwise
    always @(posedge clk)
    begin
        multi_suspend <= 1'b0;
        multi_done <= 1'b0;
        multi_next_reg <= ~multi_next_reg;
        if (start)
        begin
            cur <= resume_valid ? resume_index : 4'h0;
            first_reg <= resume_valid ? resume_index : 4'h0;
            busy <= 1'b1;
        end
        else if (busy && irq)
        begin
            multi_suspend <= 1'b1;
            multi_next_reg <= cur;
            busy <= 1'b0;
        end
        else if (busy)
        begin
            multi_done <= (cur == 4'hf);
            busy <= (cur != 4'hf);
            cur <= cur + 4'h1;
        end
    end
endmodule // core_pipe_model

`default_nettype wire

// >>> testbench.sv
/*
 Self-checking bench for the status word: strobe sequences with
 expected values for flags, exceptions, blocks and multi transfers.
 Assumes the checker and pipeline model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module testbench;
    localparam [7:0] s_flag = 8'h80, s_sat = 8'h40, s_wr = 8'h20, s_rd = 8'h10;
    localparam [7:0] s_ent = 8'h08, s_ret = 8'h04, s_blk = 8'h02, s_adv = 8'h01;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] stb = 8'h00;
    logic flag_n_in, flag_z_in, flag_c_in, flag_v_in, exc_entry_ext, mstart, mirq;
    logic [2:0] sw_write_sel, sw_read_sel;
    logic [31:0] sw_wdata, exc_return_word;
    logic [8:0] exc_entry_num, exc_return_num, last;
    logic [7:0] cond_block_code;
    wire flag_update, sat_event, sw_write, sw_read, exc_entry, exc_return, cond_block_start, cond_instr_done;
    wire sw_rvalid, entry_refused, resume_valid, cond_active, isa_mode, multi_suspend, multi_done;
    wire [31:0] sw_rdata, stacked_word, status_word;
    wire [3:0] resume_index, cond_code, multi_next_reg, first_reg;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    int i;

    assign {flag_update, sat_event, sw_write, sw_read, exc_entry, exc_return, cond_block_start, cond_instr_done} = stb;

    program_status_register dut (.clk(clk), .rst(rst), .flag_update(flag_update), .flag_n_in(flag_n_in),
        .flag_z_in(flag_z_in), .flag_c_in(flag_c_in), .flag_v_in(flag_v_in), .sat_event(sat_event),
        .sw_write(sw_write), .sw_write_sel(sw_write_sel), .sw_wdata(sw_wdata), .sw_read(sw_read),
        .sw_read_sel(sw_read_sel), .sw_rdata(sw_rdata), .sw_rvalid(sw_rvalid), .exc_entry(exc_entry),
        .exc_entry_ext(exc_entry_ext), .exc_entry_num(exc_entry_num), .entry_refused(entry_refused),
        .stacked_word(stacked_word), .exc_return(exc_return), .exc_return_num(exc_return_num),
        .exc_return_word(exc_return_word), .resume_valid(resume_valid), .resume_index(resume_index),
        .cond_block_start(cond_block_start), .cond_block_code(cond_block_code),
        .cond_instr_done(cond_instr_done), .cond_active(cond_active), .cond_code(cond_code),
        .multi_suspend(multi_suspend), .multi_next_reg(multi_next_reg), .multi_done(multi_done),
        .status_word(status_word), .isa_mode(isa_mode));

    core_pipe_model pipe (.clk(clk), .start(mstart), .irq(mirq), .resume_valid(resume_valid),
        .resume_index(resume_index), .multi_suspend(multi_suspend), .multi_next_reg(multi_next_reg),
        .multi_done(multi_done), .first_reg(first_reg));

    // ==========
    // Clock, watchdog and closing
    always #50 clk = ~clk;

    // A hang costs a mismatch rather than an endless run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========
    // Access tasks
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits a cycle first so a strobe is never lowered and raised in one step
    task go(input logic [7:0] s);
        @(negedge clk);
        stb = s;
        @(negedge clk);
        stb = 8'h00;
    endtask

    task rd(input logic [2:0] sel, input logic [31:0] exp);
        sw_read_sel = sel;
        go(s_rd);
        `CHK(sw_rvalid, 1'b1)
        `CHK(sw_rdata, exp)
    endtask

    // ==========
    // Main sequence
    initial
    begin
        {flag_n_in, flag_z_in, flag_c_in, flag_v_in, exc_entry_ext, mstart, mirq} = 7'h00;
        {sw_write_sel, sw_read_sel, sw_wdata, exc_return_word} = 70'h0;
        {exc_entry_num, exc_return_num, last, cond_block_code} = 35'h0;
        step(8);
        rst = 1'b0;
        step(2);
        `CHK(status_word, 32'h01000000)
        rd(3'b111, 32'h00000000);
        for (i = 0; i < 5; i++)
        begin
            {flag_n_in, flag_z_in, flag_c_in, flag_v_in} = 4'h8 >> i;
            go(s_flag);
            step(1);
            `CHK(status_word[31:28], 4'h8 >> i)
            rd(3'b001, {4'h8 >> i, 28'h0});
        end
        sw_write_sel = 3'b110;
        sw_wdata = 32'hffffffff;
        go(s_wr);
        step(1);
        `CHK({status_word[31:27], status_word[8:0]}, 14'h0000)
        go(s_sat);
        step(1);
        `CHK(status_word[27], 1'b1)
        {flag_n_in, flag_z_in, flag_c_in, flag_v_in} = 4'h9;
        go(s_flag);
        step(1);
        `CHK(status_word[31:27], 5'h13)
        sw_write_sel = 3'b001;
        sw_wdata = 32'ha0000000;
        go(s_wr);
        step(1);
        `CHK(status_word[31:27], 5'h14)
        // Saturation in the same cycle as a clearing write must win
        sw_wdata = 32'h00000000;
        go(s_sat | s_wr);
        step(1);
        `CHK(status_word[31:27], 5'h01)
        for (i = 0; i < 17; i++)
        begin
            exc_entry_num = i[8:0];
            go(s_ent);
            `CHK(entry_refused, !(i inside {[2:6], 11, 14, 15}))
            step(1);
            if (i inside {[2:6], 11, 14, 15})
                last = i[8:0];
            `CHK(status_word[8:0], last)
        end
        exc_entry_ext = 1'b1;
        for (i = 0; i < 2; i++)
        begin
            exc_entry_num = i ? 9'h1ef : 9'h000;
            go(s_ent);
            step(1);
            `CHK(status_word[8:0], exc_entry_num + 9'h010)
        end
        sw_write_sel = 3'b011;
        sw_wdata = 32'h00000005;
        go(s_wr);
        step(1);
        `CHK({status_word[31:27], status_word[8:0]}, 14'h01ff)
        rd(3'b011, 32'h000001ff);
        go(s_ret);
        cond_block_code = 8'h16;
        go(s_blk);
        step(1);
        `CHK({cond_active, cond_code}, 5'h11)
        rd(3'b100, 32'h00000000);
        exc_entry_num = 9'h001;
        go(s_ent);
        `CHK({stacked_word[26:24], stacked_word[15:10]}, 9'h145)
        step(1);
        `CHK(cond_active, 1'b0)
        exc_return_word = stacked_word;
        go(s_ret);
        step(1);
        `CHK({cond_active, cond_code}, 5'h11)
        for (i = 0; i < 3; i++)
        begin
            go(s_adv);
            step(1);
            `CHK({cond_active, cond_code}, i == 2 ? 5'h00 : {4'h8, i[0]})
        end
        mstart = 1'b1;
        step(1);
        mstart = 1'b0;
        step(3);
        mirq = 1'b1;
        step(1);
        mirq = 1'b0;
        step(2);
        `CHK({resume_valid, resume_index, status_word[15:12]}, 9'h133)
        go(s_ent);
        `CHK(stacked_word[15:12], 4'h3)
        exc_return_word = stacked_word;
        go(s_ret);
        step(1);
        `CHK({resume_valid, resume_index}, 5'h13)
        mstart = 1'b1;
        step(1);
        mstart = 1'b0;
        `CHK(first_reg, 4'h3)
        step(20);
        `CHK(resume_valid, 1'b0)
        tally_and_finish;
    end
endmodule // testbench

bind program_status_register status_word_chk chk (.clk(clk), .rst(rst), .flag_update(flag_update),
    .flag_n_in(flag_n_in), .flag_z_in(flag_z_in), .flag_c_in(flag_c_in), .flag_v_in(flag_v_in),
    .sat_event(sat_event), .sw_write(sw_write), .sw_read(sw_read), .sw_rvalid(sw_rvalid),
    .sw_rdata(sw_rdata), .exc_entry(exc_entry), .exc_entry_ext(exc_entry_ext),
    .exc_entry_num(exc_entry_num), .entry_refused(entry_refused), .stacked_word(stacked_word),
    .exc_return(exc_return), .resume_valid(resume_valid), .resume_index(resume_index),
    .cond_active(cond_active), .status_word(status_word), .isa_mode(isa_mode));

`default_nettype wire
